// file: src/seg_map_pkg.sv
package seg_map_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CHAR_CFG     = 8'h40;  // char_map_config
  localparam logic [7:0] OFF_CHAR_DATA    = 8'h44;  // char_map_data
  localparam logic [7:0] OFF_AUTO_CFG     = 8'h48;  // auto_char_map_config
  localparam logic [7:0] OFF_AUTO_DATA    = 8'h4c;  // auto_char_map_data
  localparam logic [7:0] OFF_BIT_CFG      = 8'h50;  // auto_bit_map_config
  localparam logic [7:0] OFF_BIT_DATA     = 8'h54;  // auto_bit_map_data
  localparam logic [7:0] OFF_IRQ_SET      = 8'h58;  // irq_enable_set
  localparam logic [7:0] OFF_IRQ_CLR      = 8'h5c;  // irq_enable_clear
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h60;  // irq_mask_state
  localparam logic [7:0] OFF_REVISION     = 8'h64;  // module_revision
  localparam logic [7:0] OFF_STATUS       = 8'h0c;  // status_reg
  localparam logic [7:0] OFF_STATUS_CLEAR = 8'h10;  // status_clear_reg
  localparam logic [7:0] OFF_SEG_WORD     = 8'h80;  // display window, 8 words

  // ----------------------------------------------------------------
  // sizes and field positions
  // ----------------------------------------------------------------
  localparam int MEM_BYTES    = 32;                // display memory bytes
  localparam int SEG_WORDS    = 8;                 // readable window words
  localparam int PACE_DIV_DEF = 16;                // frame ticks per pace step
  localparam logic [31:0] REV_VALUE = 32'h00000a05; // arbitrary value
  localparam logic [31:0] CHAR_CFG_MASK = 32'h00003f07;
  localparam logic [31:0] AUTO_CFG_MASK = 32'h0fff3f7f;
  localparam logic [31:0] BIT_CFG_MASK  = 32'h001f1f07;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // digit type codes
  typedef enum logic [1:0] {
    DIG_7S_3C  = 2'h0,
    DIG_7S_4C  = 2'h1,
    DIG_14S_4C = 2'h2,
    DIG_16S_3C = 2'h3
  } digit_kind_type;

  // character mapping configuration
  typedef struct packed {
    logic [5:0]     first_segment_index;
    digit_kind_type digit_type;
    logic           digit_reverse;
  } char_cfg_type;

  // automated character mapping configuration
  typedef struct packed {
    logic [3:0]     digit_count;
    logic [7:0]     steps;
    logic [5:0]     first_segment_index;
    digit_kind_type digit_type;
    logic           digit_reverse;
    logic           scroll_mode;
    logic [1:0]     pace_counter_select;
    logic           enable;
  } auto_cfg_type;

  // automated bit mapping configuration
  typedef struct packed {
    logic [4:0] frame_size;
    logic [1:0] pace_counter_select;
    logic       enable;
  } bit_cfg_type;

  // axi-lite slave side outputs
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } axi_out_type;

  // automated sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT,
    SEQ_STEP
  } seq_state_type;

endpackage

// file: src/segment_lcd_char_bit_mapper.sv
`timescale 1ns/1ps
// Function
// - decoded pattern starts at first segment index
// - digit type selects segment/common layout
// - reverse bit flips digit ordering
// - mode bit selects sequential or scrolling
// - pace from selected frame counter
// - auto char mapping runs only when enabled
// - frame is size writes to bit data
// - bit data writes always update memory; frame counting only when enabled
// - masked byte update of display memory
// - enable-set write sets mask bits
// - enable-clear write clears mask bits
// - mask readable, resets zero, bit zero
// - read-only revision with version and variant
// - rollover flag set, cleared by status clear
module segment_lcd_char_bit_mapper
  import seg_map_pkg::*;
#(
  parameter int PACE_DIV = PACE_DIV_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        frame_counter_zero,  // tick pulses, mclk domain
  input  wire logic        frame_counter_one,
  input  wire logic        frame_counter_two,
  input  wire logic        awvalid,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        bready,
  input  wire logic        arvalid,
  input  wire logic [7:0]  araddr,
  input  wire logic        rready,
  output logic             awready,
  output logic             wready,
  output logic             bvalid,
  output logic [1:0]       bresp,
  output logic             arready,
  output logic             rvalid,
  output logic [1:0]       rresp,
  output logic [31:0]      rdata,
  output logic             irq,
  output logic             auto_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          rst_sync;     // reset release pipe
    axi_out_type         bus;          // bus outputs
    logic                aw_held;      // address taken, waiting data
    logic                w_held;       // data taken, waiting address
    logic [7:0]          aw_addr;      // captured write address
    logic [31:0]         w_data;       // captured write data
    char_cfg_type        char_cfg;     // char_map_config
    auto_cfg_type        auto_cfg;     // auto_char_map_config
    bit_cfg_type         bit_cfg;      // auto_bit_map_config
    logic                irq_mask;     // irq_mask_state bit 0
    logic                rollover;     // counter_zero_rollover flag
    logic                irq;          // interrupt output
    logic [MEM_BYTES*8-1:0] mem;       // display memory
    logic [3:0]          digit_idx;    // next auto digit slot
    logic [7:0]          step_idx;     // scroll steps done
    logic [4:0]          bit_cnt;      // bit-map writes in frame
    logic [7:0]          pace_cnt;     // pace ticks
    seq_state_type       seq;          // auto sequencer state
    logic                busy;         // auto mapping active
  } state_type;

  state_type cur_ff;   // registered state
  state_type nxt_cur;  // next state

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // segment pattern lookup for 7-bit codes, 16 bits wide
  function automatic logic [15:0] glyph(input logic [6:0] code);
    logic [15:0] g;
    g = 16'h0000;
    case (code)
      7'h30: g = 16'h003f;  // 0
      7'h31: g = 16'h0006;
      7'h32: g = 16'h005b;
      7'h33: g = 16'h004f;
      7'h34: g = 16'h0066;
      7'h35: g = 16'h006d;
      7'h36: g = 16'h007d;
      7'h37: g = 16'h0007;
      7'h38: g = 16'h007f;
      7'h39: g = 16'h006f;
      7'h41: g = 16'h0077;  // A
      7'h42: g = 16'h007c;
      7'h43: g = 16'h0039;
      7'h44: g = 16'h005e;
      7'h45: g = 16'h0079;
      7'h46: g = 16'h0071;
      7'h2d: g = 16'h0040;  // dash
      default: g = 16'h0000;
    endcase
    return g;
  endfunction

  // width of a digit in segment terminals per common row
  function automatic logic [5:0] digit_width(input digit_kind_type t);
    logic [5:0] w;
    w = 6'h0;
    case (t)
      DIG_7S_3C:  w = 6'h3;
      DIG_7S_4C:  w = 6'h2;
      DIG_14S_4C: w = 6'h4;
      default:    w = 6'h6;
    endcase
    return w;
  endfunction

  // commons used by a digit type
  function automatic logic [2:0] digit_rows(input digit_kind_type t);
    return (t == DIG_7S_3C || t == DIG_16S_3C) ? 3'h3 : 3'h4;
  endfunction

  // write one decoded digit into memory; memory laid as 4 rows of 64 bits
  function automatic logic [MEM_BYTES*8-1:0] put_digit(
    input logic [MEM_BYTES*8-1:0] m,
    input logic [6:0]             code,
    input digit_kind_type         t,
    input logic                   rev,
    input logic [5:0]             seg0,
    input logic [3:0]             slot
  );
    logic [MEM_BYTES*8-1:0] r;
    logic [15:0]            g;
    logic [5:0]             w;
    logic [2:0]             rows;
    logic [7:0]             base;
    logic [7:0]             col;
    logic [4:0]             k;
    r    = m;
    g    = glyph(code);
    w    = digit_width(t);
    rows = digit_rows(t);
    // digits advance rightward, or leftward when reversed
    base = rev ? 8'(seg0) - 8'(slot) * 8'(w)
               : 8'(seg0) + 8'(slot) * 8'(w);
    for (int i = 0; i < 16; i++) begin
      k   = 5'(i);
      col = base + 8'(k % 5'(w));
      if ((k / 5'(w)) < 5'(rows) && k < 5'(w) * 5'(rows) && col < 8'h40) begin
        r[(k / 5'(w)) * 64 + col] = g[i];
      end
    end
    return r;
  endfunction

  // selected pace tick
  function automatic logic pick_tick(input logic [1:0] sel, input logic [2:0] t);
    logic p;
    p = 1'b0;
    case (sel)
      2'h0:    p = t[0];
      2'h1:    p = t[1];
      2'h2:    p = t[2];
      default: p = 1'b0;  // reserved, no pace
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers for frame-counter ticks
  // ----------------------------------------------------------------
  logic [2:0] tick_s1_ff;  // first stage
  logic [2:0] tick_s2_ff;  // second stage
  logic [2:0] tick_s3_ff;  // edge reference

  // two-flop sync plus edge detect on second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_s1_ff <= 3'h0;
      tick_s2_ff <= 3'h0;
      tick_s3_ff <= 3'h0;
    end else if (clk_en) begin
      tick_s1_ff <= {frame_counter_two, frame_counter_one, frame_counter_zero};
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end

  logic [2:0] tick_rise;  // one pulse per counter rollover
  assign tick_rise = tick_s2_ff & ~tick_s3_ff;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic        wr_fire;   // both halves of write present
  logic [31:0] wd;        // merged write data
  logic [7:0]  wa;        // write address
  logic        pace;      // selected pace tick

  always_comb begin
    nxt_cur  = cur_ff;
    nxt_cur.rst_sync = {cur_ff.rst_sync[0], 1'b1};
    wr_fire  = 1'b0;
    wd       = 32'h0;
    wa       = 8'h0;
    pace     = 1'b0;

    // write channel capture
    if (awvalid && cur_ff.bus.awready) begin
      nxt_cur.aw_held     = 1'b1;
      nxt_cur.aw_addr     = awaddr;
      nxt_cur.bus.awready = 1'b0;
    end
    if (wvalid && cur_ff.bus.wready) begin
      nxt_cur.w_held     = 1'b1;
      nxt_cur.bus.wready = 1'b0;
      for (int b = 0; b < 4; b++) begin
        nxt_cur.w_data[b*8 +: 8] = wstrb[b] ? wdata[b*8 +: 8] : 8'h00;
      end
    end

    // rollover event; set wins over clear below
    if (tick_rise[0]) begin
      nxt_cur.rollover = 1'b1;
    end

    // perform write when both halves held and no response pending
    if (cur_ff.aw_held && cur_ff.w_held && !cur_ff.bus.bvalid) begin
      wr_fire = 1'b1;
      wd      = cur_ff.w_data;
      wa      = cur_ff.aw_addr & 8'hfc;
      nxt_cur.aw_held     = 1'b0;
      nxt_cur.w_held      = 1'b0;
      nxt_cur.bus.bvalid  = 1'b1;
      nxt_cur.bus.bresp   = RESP_OKAY;
      if (wa == OFF_CHAR_CFG) begin
        nxt_cur.char_cfg = char_cfg_type'({wd[13:8], wd[2:0]});
      end else if (wa == OFF_CHAR_DATA) begin
        nxt_cur.mem = put_digit(cur_ff.mem, wd[6:0], cur_ff.char_cfg.digit_type,
          cur_ff.char_cfg.digit_reverse, cur_ff.char_cfg.first_segment_index,
          4'h0);
      end else if (wa == OFF_AUTO_CFG) begin
        nxt_cur.auto_cfg = auto_cfg_type'({wd[27:24], wd[23:16], wd[13:8], wd[6:0]});
        nxt_cur.digit_idx = 4'h0;
        nxt_cur.step_idx  = 8'h0;
      end else if (wa == OFF_AUTO_DATA) begin
        if (cur_ff.auto_cfg.enable) begin
          nxt_cur.mem = put_digit(cur_ff.mem, wd[6:0], cur_ff.auto_cfg.digit_type,
            cur_ff.auto_cfg.digit_reverse, cur_ff.auto_cfg.first_segment_index,
            cur_ff.digit_idx);
          // digit_count above one is software's duty
          if (cur_ff.digit_idx + 4'h1 >= cur_ff.auto_cfg.digit_count) begin
            nxt_cur.digit_idx = 4'h0;
            nxt_cur.seq       = SEQ_WAIT;
          end else begin
            nxt_cur.digit_idx = cur_ff.digit_idx + 4'h1;
          end
        end
      end else if (wa == OFF_BIT_CFG) begin
        nxt_cur.bit_cfg = bit_cfg_type'({wd[12:8], wd[2:0]});
        nxt_cur.bit_cnt = 5'h0;
      end else if (wa == OFF_BIT_DATA) begin
        // bits with mask bit set keep old value
        if (6'(wd[20:16]) < 6'(MEM_BYTES)) begin
          nxt_cur.mem[wd[20:16]*8 +: 8] =
            (cur_ff.mem[wd[20:16]*8 +: 8] & wd[15:8]) | (wd[7:0] & ~wd[15:8]);
        end
        if (cur_ff.bit_cfg.enable) begin
          if (cur_ff.bit_cnt + 5'h1 >= cur_ff.bit_cfg.frame_size) begin
            nxt_cur.bit_cnt = 5'h0;
            nxt_cur.seq     = SEQ_WAIT;
          end else begin
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 5'h1;
          end
        end
      end else if (wa == OFF_IRQ_SET) begin
        if (wd[0]) nxt_cur.irq_mask = 1'b1;
      end else if (wa == OFF_IRQ_CLR) begin
        if (wd[0]) nxt_cur.irq_mask = 1'b0;
      end else if (wa == OFF_STATUS_CLEAR) begin
        if (wd[0] && !tick_rise[0]) nxt_cur.rollover = 1'b0;
      end else if (wa == OFF_IRQ_MASK || wa == OFF_REVISION || wa == OFF_STATUS) begin
        nxt_cur.bus.bresp = RESP_OKAY;  // read-only, write ignored
      end else begin
        nxt_cur.bus.bresp = RESP_SLVERR;  // unmapped
      end
    end

    // write response handshake
    if (cur_ff.bus.bvalid && bready) begin
      nxt_cur.bus.bvalid  = 1'b0;
      nxt_cur.bus.awready = 1'b1;
      nxt_cur.bus.wready  = 1'b1;
    end

    // read channel
    if (arvalid && cur_ff.bus.arready) begin
      nxt_cur.bus.arready = 1'b0;
      nxt_cur.bus.rvalid  = 1'b1;
      nxt_cur.bus.rresp   = RESP_OKAY;
      nxt_cur.bus.rdata   = 32'h0;
      if ((araddr & 8'hfc) == OFF_CHAR_CFG) begin
        nxt_cur.bus.rdata = {18'h0, cur_ff.char_cfg[8:3], 5'h0, cur_ff.char_cfg[2:0]};
      end else if ((araddr & 8'hfc) == OFF_AUTO_CFG) begin
        nxt_cur.bus.rdata = {4'h0, cur_ff.auto_cfg[24:13], 2'h0,
                             cur_ff.auto_cfg[12:7], 1'b0, cur_ff.auto_cfg[6:0]};
      end else if ((araddr & 8'hfc) == OFF_BIT_CFG) begin
        nxt_cur.bus.rdata = {19'h0, cur_ff.bit_cfg[7:3], 5'h0, cur_ff.bit_cfg[2:0]};
      end else if ((araddr & 8'hfc) == OFF_IRQ_MASK) begin
        nxt_cur.bus.rdata = {31'h0, cur_ff.irq_mask};
      end else if ((araddr & 8'hfc) == OFF_REVISION) begin
        nxt_cur.bus.rdata = REV_VALUE;
      end else if ((araddr & 8'hfc) == OFF_STATUS) begin
        nxt_cur.bus.rdata = {31'h0, cur_ff.rollover};
      end else if ((araddr & 8'hfc) >= OFF_SEG_WORD &&
                   (araddr & 8'hfc) < OFF_SEG_WORD + 8'(SEG_WORDS * 4)) begin
        nxt_cur.bus.rdata = cur_ff.mem[araddr[4:2]*32 +: 32];
      end else if ((araddr & 8'hfc) == OFF_CHAR_DATA || (araddr & 8'hfc) == OFF_AUTO_DATA
                   || (araddr & 8'hfc) == OFF_BIT_DATA || (araddr & 8'hfc) == OFF_IRQ_SET
                   || (araddr & 8'hfc) == OFF_IRQ_CLR
                   || (araddr & 8'hfc) == OFF_STATUS_CLEAR) begin
        nxt_cur.bus.rdata = 32'h0;  // write-only reads zero
      end else begin
        nxt_cur.bus.rresp = RESP_SLVERR;
      end
    end
    if (cur_ff.bus.rvalid && rready) begin
      nxt_cur.bus.rvalid  = 1'b0;
      nxt_cur.bus.arready = 1'b1;
    end

    // auto sequencer: waits a paced interval after each full frame
    pace = cur_ff.auto_cfg.enable
         ? pick_tick(cur_ff.auto_cfg.pace_counter_select, tick_rise)
         : pick_tick(cur_ff.bit_cfg.pace_counter_select, tick_rise);
    case (cur_ff.seq)
      SEQ_IDLE: begin
        nxt_cur.busy = 1'b0;
      end
      SEQ_WAIT: begin
        nxt_cur.busy = 1'b1;
        if (!cur_ff.auto_cfg.enable && !cur_ff.bit_cfg.enable) begin
          nxt_cur.seq = SEQ_IDLE;
        end else if (pace) begin
          nxt_cur.pace_cnt = cur_ff.pace_cnt + 8'h1;
          if (cur_ff.pace_cnt + 8'h1 >= 8'(PACE_DIV)) begin
            nxt_cur.pace_cnt = 8'h0;
            nxt_cur.seq      = SEQ_STEP;
          end
        end
      end
      SEQ_STEP: begin
        // scrolling counts steps, sequential frames simply advance
        if (cur_ff.auto_cfg.scroll_mode && cur_ff.auto_cfg.enable) begin
          if (cur_ff.step_idx + 8'h1 >= cur_ff.auto_cfg.steps) begin
            nxt_cur.step_idx = 8'h0;
          end else begin
            nxt_cur.step_idx = cur_ff.step_idx + 8'h1;
          end
        end
        nxt_cur.seq  = SEQ_IDLE;
        nxt_cur.busy = 1'b0;
      end
      default: nxt_cur.seq = SEQ_IDLE;
    endcase

    nxt_cur.irq = nxt_cur.rollover & nxt_cur.irq_mask;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // display memory carries no reset meaning but is cleared for determinism
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else if (!cur_ff.rst_sync[1]) begin
      cur_ff              <= '0;
      cur_ff.rst_sync     <= {cur_ff.rst_sync[0], 1'b1};
      cur_ff.bus.awready  <= cur_ff.rst_sync[0];
      cur_ff.bus.wready   <= cur_ff.rst_sync[0];
      cur_ff.bus.arready  <= cur_ff.rst_sync[0];
    end else if (clk_en) begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready   = cur_ff.bus.awready;
  assign wready    = cur_ff.bus.wready;
  assign bvalid    = cur_ff.bus.bvalid;
  assign bresp     = cur_ff.bus.bresp;
  assign arready   = cur_ff.bus.arready;
  assign rvalid    = cur_ff.bus.rvalid;
  assign rresp     = cur_ff.bus.rresp;
  assign rdata     = cur_ff.bus.rdata;
  assign irq       = cur_ff.irq;
  assign auto_busy = cur_ff.busy;

endmodule

// file: bench/seg_map_chk.sv
`timescale 1ns/1ps
module seg_map_chk
  import seg_map_pkg::*;
#(
  parameter int PACE_DIV = PACE_DIV_DEF
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic [7:0]  araddr,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [1:0]  rresp,
  input wire logic [31:0] rdata
);
  // ----------------------------------------------------------------
  // handshake timing and fixed read values
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // read address taken for one word
  sequence s_rd(a); arvalid && arready && clk_en && araddr[7:2] == a; endsequence
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response not held");
  property p_r_lat; arvalid && arready && clk_en |=> rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat; awvalid && awready && wvalid && wready && clk_en |-> ##[1:3] bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_busy; bvalid |-> !awready && !wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("ready while response pending");
  property p_rev; s_rd(OFF_REVISION[7:2]) |=> rdata == REV_VALUE && rresp == RESP_OKAY; endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  property p_mask; s_rd(OFF_IRQ_MASK[7:2]) |=> rdata[31:1] == 31'h0; endproperty
  a_mask: assert property (p_mask) else $error("mask has unused bits set");
  property p_wo; s_rd(OFF_CHAR_DATA[7:2]) |=> rdata == 32'h0 && rresp == RESP_OKAY; endproperty
  a_wo: assert property (p_wo) else $error("write-only read not zero");
  property p_bad; s_rd(6'h0) |=> rresp == RESP_SLVERR && rdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped read not refused");
endmodule

bind segment_lcd_char_bit_mapper seg_map_chk #(.PACE_DIV(PACE_DIV)) u_chk (.mclk, .rst_n,
  .clk_en, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .araddr, .arready, .rvalid, .rready, .rresp, .rdata);

// file: bench/axil_host.sv
`timescale 1ns/1ps
module axil_host (
  input wire logic        mclk,
  output logic            awvalid,
  output logic [7:0]      awaddr,
  output logic            wvalid,
  output logic [31:0]     wdata,
  output logic [3:0]      wstrb,
  output logic            bready,
  output logic            arvalid,
  output logic [7:0]      araddr,
  output logic            rready,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [1:0]  rresp,
  input wire logic [31:0] rdata
);
  // ----------------------------------------------------------------
  // processor side of the register bus
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
  end
  // address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // read address dropped when taken, then answer awaited
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import seg_map_pkg::*;
  logic         mclk, rst_n, clk_en, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, irq, auto_busy;
  logic [2:0]   fc;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, d, v;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, r;
  logic [255:0] mem, sel;
  int           n_mismatch = 0, checks_done = 0, cyc = 0;

  segment_lcd_char_bit_mapper #(.PACE_DIV(2)) dut (.mclk, .rst_n, .clk_en,
    .frame_counter_zero(fc[0]), .frame_counter_one(fc[1]), .frame_counter_two(fc[2]),
    .awvalid, .awaddr, .wvalid, .wdata, .wstrb, .bready, .arvalid, .araddr, .rready,
    .awready, .wready, .bvalid, .bresp, .arready, .rvalid, .rresp, .rdata, .irq, .auto_busy);
  axil_host host (.mclk, .awvalid, .awaddr, .wvalid, .wdata, .wstrb, .bready, .arvalid,
    .araddr, .rready, .awready, .wready, .bvalid, .bresp, .arready, .rvalid, .rresp, .rdata);

  // ----------------------------------------------------------------
  // clock, compare and bus helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er = RESP_OKAY);
    host.wr(a, x, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
          input logic [1:0] er = RESP_OKAY);
    host.rd(a, d, r);
    chk("rresp", {30'h0, r}, {30'h0, er});
    chk("rdata", d & m, e);
  endtask
  // one rising edge on a frame counter tick line
  task tick(input int k);
    @(posedge mclk) fc[k] <= 1'b1;
    repeat (3) @(posedge mclk);
    fc[k] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // all display bytes to zero, then the window read back
  task clear_mem;
    for (int i = 0; i < MEM_BYTES; i++) wr(OFF_BIT_DATA, {11'h0, 5'(i), 16'h0});
  endtask
  task dump;
    for (int i = 0; i < SEG_WORDS; i++) begin
      host.rd(OFF_SEG_WORD + 8'(4 * i), d, r);
      mem[i*32 +: 32] = d;
    end
  endtask
  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run;
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    fc = 3'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(OFF_CHAR_CFG, 0);
    rd(OFF_AUTO_CFG, 0);
    rd(OFF_BIT_CFG, 0);
    rd(OFF_IRQ_MASK, 0);
    wr(OFF_REVISION, 0);
    rd(OFF_REVISION, REV_VALUE);
    rd(OFF_CHAR_DATA, 0);
    rd(8'h00, 0, 32'hffffffff, RESP_SLVERR);
    wr(8'h3c, 1, RESP_SLVERR);
    wr(OFF_CHAR_CFG, 32'hffffffff);
    rd(OFF_CHAR_CFG, CHAR_CFG_MASK);
    // each digit type placed from its start segment
    for (int t = 0; t < 4; t++) begin
      v = {18'h0, 6'(8 * t + 8), 5'h0, 2'(t), 1'b0};
      wr(OFF_CHAR_CFG, v);
      rd(OFF_CHAR_CFG, v);
      clear_mem;
      wr(OFF_CHAR_DATA, 32'h38);
      dump;
      sel = '0;
      for (int c = 0; c < 4; c++) sel[c*64 + 8*t + 8 +: 8] = 8'hff;
      chk("outside", 32'($countones(mem & ~sel)), 0);
      chk("lit", {31'h0, $countones(mem) > 0}, 1);
      if (t < 2) chk("seg7", 32'($countones(mem)), 7);
    end
    // masked byte update at the last offset
    clear_mem;
    wr(OFF_BIT_DATA, {11'h0, 5'd31, 8'h00, 8'h3c});
    wr(OFF_BIT_DATA, {11'h0, 5'd31, 8'h0f, 8'ha5});
    rd(OFF_SEG_WORD + 8'h1c, 32'hac000000);
    wr(OFF_BIT_CFG, 32'h00000201);
    rd(OFF_BIT_CFG, 32'h00000201);
    wr(OFF_BIT_CFG, 0);
    // rollover flag, mask and interrupt
    tick(0);
    rd(OFF_STATUS, 1, 1);
    chk("irq", {31'h0, irq}, 0);
    wr(OFF_IRQ_SET, 0);
    rd(OFF_IRQ_MASK, 0);
    wr(OFF_IRQ_SET, 32'hffffffff);
    rd(OFF_IRQ_MASK, 1);
    chk("irq", {31'h0, irq}, 1);
    wr(OFF_IRQ_CLR, 0);
    rd(OFF_IRQ_MASK, 1);
    wr(OFF_IRQ_CLR, 1);
    rd(OFF_IRQ_MASK, 0);
    chk("irq", {31'h0, irq}, 0);
    wr(OFF_IRQ_SET, 1);
    wr(OFF_STATUS_CLEAR, 0);
    rd(OFF_STATUS, 1, 1);
    wr(OFF_STATUS_CLEAR, 1);
    rd(OFF_STATUS, 0, 1);
    chk("irq", {31'h0, irq}, 0);
    // automated mapping gated by enable and paced by its own counter
    wr(OFF_AUTO_CFG, 32'h0202000a);
    rd(OFF_AUTO_CFG, 32'h0202000a);
    wr(OFF_AUTO_DATA, 32'h31);
    repeat (4) @(posedge mclk);
    chk("busy off", {31'h0, auto_busy}, 0);
    for (int s = 0; s < 3; s++) begin
      v = {4'h0, 4'd2, 8'd1, 9'h0, 4'h0, 2'(s), 1'b1};
      wr(OFF_AUTO_CFG, v);
      rd(OFF_AUTO_CFG, v);
      repeat (2) wr(OFF_AUTO_DATA, 32'h31);
      tick((s + 1) % 3);
      tick((s + 2) % 3);
      chk("busy wait", {31'h0, auto_busy}, 1);
      wr(OFF_AUTO_CFG, 0);
      repeat (4) @(posedge mclk);
      chk("busy stop", {31'h0, auto_busy}, 0);
    end
    wr(OFF_AUTO_CFG, v);
    repeat (2) wr(OFF_AUTO_DATA, 32'h31);
    tick(2);
    chk("busy half", {31'h0, auto_busy}, 1);
    tick(2);
    chk("busy paced", {31'h0, auto_busy}, 0);
    complete_run;
  end
endmodule
